// file: bench/bus_master.sv
// two-wire bus master model: drives the bus clock and its side of the open-drain data line
`timescale 1ns/1ns
module bus_master (
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	// clock stands high between frames; data bits move only while the clock is low
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// works as a first or a repeated start
	task automatic start();
		#20 sda_o = 1'b1;
		#40 scl_o = 1'b1;
		#60 sda_o = 1'b0;
		#60 scl_o = 1'b0;
	endtask
	task automatic stop();
		#20 sda_o = 1'b0;
		#40 scl_o = 1'b1;
		#60 sda_o = 1'b1;
		#100;
	endtask
	// one bit of a 125 ns bus clock period
	task automatic bitw(input logic b);
		#20 sda_o = b;
		#42 scl_o = 1'b1;
		#63 scl_o = 1'b0;
	endtask
	// releasing the line lets the pull-up or the device decide its level
	task automatic bitr(output logic r);
		#20 sda_o = 1'b1;
		#42 scl_o = 1'b1;
		#30 r = sda_i;
		#33 scl_o = 1'b0;
	endtask
	task automatic wbyte(input logic [7:0] d, output logic nack);
		for (int i = 7; i >= 0; i--) begin
			bitw(d[i]);
		end
		bitr(nack);
	endtask
	task automatic rbyte(input logic nack_in, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			bitr(d[i]);
		end
		bitw(nack_in);
	endtask
endmodule

// file: bench/eeprom_slave_test.sv
// self-checking bench for the serial eeprom slave
`timescale 1ns/1ns
module eeprom_slave_test;
	localparam logic [2:0] strap = 3'h5;
	localparam logic [7:0] dev_w = {eeprom_pkg::type_prefix, strap, 1'b0};
	typedef struct packed {
		logic [7:0] dev;
		logic nack;
	} row_s;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic write_guard_i = 1'b0;
	logic scl, m_sda, sda_o, sda_oe_o, busy_o, nack;
	logic [7:0] d;
	int fail_count = 0;
	int n_compared = 0;
	int polls;
	row_s rows [10];
	// pull-up: the line is low when either party pulls it
	wire sda = m_sda & ~sda_oe_o;
	always #10 clk_i = ~clk_i;
	// short write time keeps polling loops brief
	eeprom_slave #(.write_cycles(200)) eeprom_slave_inst (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl),
		.sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .strap_pin_bit0(strap[0]),
		.strap_pin_bit1(strap[1]), .strap_pin_bit2(strap[2]), .write_guard_i(write_guard_i), .busy_o(busy_o));
	bus_master bus_master_inst (.sda_i(sda), .scl_o(scl), .sda_o(m_sda));
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wrap_up();
		if (fail_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// page content after 34 bytes from offset 28: the last two overwrite the first two
	function automatic logic [7:0] pg(input int o);
		int k;
		k = (o - 28) & 31;
		if (k < 2) k += 32;
		return 8'(k) ^ 8'h5a;
	endfunction
	task automatic setaddr(input logic [7:0] hi, input logic [7:0] lo);
		bus_master_inst.start();
		bus_master_inst.wbyte(dev_w, nack);
		chk("dev ack", 8'h00, {7'h0, nack});
		bus_master_inst.wbyte(hi, nack);
		chk("hi ack", 8'h00, {7'h0, nack});
		bus_master_inst.wbyte(lo, nack);
		chk("lo ack", 8'h00, {7'h0, nack});
	endtask
	task automatic rdopen();
		bus_master_inst.start();
		bus_master_inst.wbyte(dev_w | 8'h01, nack);
		chk("read ack", 8'h00, {7'h0, nack});
	endtask
	// read polls until acknowledged, then one byte at the pointer
	task automatic poll(output logic [7:0] got);
		polls = 0;
		nack = 1'b1;
		while (nack === 1'b1 && polls < 50) begin
			bus_master_inst.start();
			bus_master_inst.wbyte(dev_w | 8'h01, nack);
			polls++;
			if (nack === 1'b1) bus_master_inst.stop();
		end
		chk("poll ack", 8'h00, {7'h0, nack});
		chk("busy done", 8'h00, {7'h0, busy_o});
		bus_master_inst.rbyte(1'b1, got);
		bus_master_inst.stop();
	endtask
	task automatic wr1(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] v, output logic [7:0] got);
		setaddr(hi, lo);
		bus_master_inst.wbyte(v, nack);
		chk("data ack", 8'h00, {7'h0, nack});
		bus_master_inst.stop();
		#300 chk("busy", 8'h01, {7'h0, busy_o});
		poll(got);
	endtask
	initial begin
		#1_000_000;
		fail_count++;
		wrap_up();
	end
	initial begin
		for (int j = 0; j < 8; j++) rows[j] = '{{eeprom_pkg::type_prefix, 3'(j), 1'b0}, 1'(j != strap)};
		rows[8] = '{{4'hb, strap, 1'b0}, 1'b1};
		rows[9] = '{{4'h2, strap, 1'b0}, 1'b1};
		repeat (4) @(posedge clk_i);
		#2 rst_i = 1'b0;
		chk("reset out", 8'h00, {6'h0, busy_o, sda_oe_o});
		// address bytes with no data: only the matching one answers, none writes
		for (int i = 0; i < 10; i++) begin
			bus_master_inst.start();
			bus_master_inst.wbyte(rows[i].dev, nack);
			chk("addr match", {7'h0, rows[i].nack}, {7'h0, nack});
			bus_master_inst.stop();
			#300 chk("no write", 8'h00, {7'h0, busy_o});
		end
		// 34-byte page write with ignored top bits; polls refused while busy
		setaddr(8'he0, 8'h3c);
		for (int k = 0; k < 34; k++) begin
			bus_master_inst.wbyte(8'(k) ^ 8'h5a, nack);
			chk("page ack", 8'h00, {7'h0, nack});
		end
		bus_master_inst.stop();
		#300 chk("busy", 8'h01, {7'h0, busy_o});
		poll(d);
		chk("polls refused", 8'h01, {7'h0, polls > 1});
		chk("pointer", pg(30), d);
		setaddr(8'h00, 8'h20);
		rdopen();
		for (int o = 0; o < 32; o++) begin
			bus_master_inst.rbyte(1'(o == 31), d);
			chk("page data", pg(o), d);
		end
		bus_master_inst.stop();
		// guarded write leaves the array alone
		@(posedge clk_i);
		#2 write_guard_i = 1'b1;
		wr1(8'h00, 8'h20, 8'hff, d);
		chk("guard ptr", pg(1), d);
		setaddr(8'h00, 8'h20);
		rdopen();
		bus_master_inst.rbyte(1'b1, d);
		chk("guarded", pg(0), d);
		bus_master_inst.stop();
		@(posedge clk_i);
		#2 write_guard_i = 1'b0;
		// sequential read across the top of memory
		wr1(8'hff, 8'hff, 8'hc3, d);
		wr1(8'h00, 8'h00, 8'h3c, d);
		setaddr(8'hff, 8'hff);
		rdopen();
		bus_master_inst.rbyte(1'b0, d);
		chk("top", 8'hc3, d);
		bus_master_inst.rbyte(1'b1, d);
		chk("wrap", 8'h3c, d);
		bus_master_inst.stop();
		wrap_up();
	end
endmodule

// file: hdl/eeprom_slave.sv
// two-wire serial eeprom slave: bus protocol, page buffer, array and write timer
`timescale 1ns/1ns
module eeprom_slave #(
	parameter int write_cycles = eeprom_pkg::write_cycles
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic strap_pin_bit0,
	input wire logic strap_pin_bit1,
	input wire logic strap_pin_bit2,
	input wire logic write_guard_i,
	output logic busy_o
);
	typedef enum logic [2:0] {st_idle, st_dev, st_hi, st_lo, st_wdata, st_rdata, st_rack} phase_e;

	// link-side state, clocked by the bus clock
	typedef struct packed {
		phase_e phase;
		logic [2:0] bit_cnt;
		logic [7:0] shift;
		logic ack_now;     // pull the line in the ninth clock
		logic [7:0] hi;
		logic [12:0] ptr;
		logic [12:0] wbase;
		logic [5:0] count;
		logic [7:0] tx;
	} link_s;

	// system-side state
	typedef struct packed {
		logic [1:0] busy_sync;
		logic [1:0] stop_sync;
		logic go_seen;
		logic busy;
		logic [31:0] timer;
		logic [5:0] idx;
		logic [12:0] base;
		logic [5:0] count;
		logic guard;
	} sys_s;

	link_s link, next_link;
	sys_s sys, next_sys;
	logic [7:0] mem [0:eeprom_pkg::mem_bytes-1];
	logic [7:0] page [0:eeprom_pkg::page_bytes-1];
	logic start_flag, stop_flag, start_ack;
	logic [1:0] guard_sync;
	logic busy_link1, busy_link;
	logic page_we;
	logic [4:0] page_wa;

	function automatic logic [12:0] page_step(input logic [12:0] a);
		page_step = {a[12:5], 5'(a[4:0] + 5'h01)};
	endfunction

	// start and stop markers: clock high while data moves
	always_ff @(negedge sda_i or posedge rst_i or posedge start_ack) begin
		if (rst_i || start_ack) begin
			start_flag <= 1'b0;
		end else if (scl_i) begin
			start_flag <= 1'b1;
		end
	end
	// stop level stands until the next start, since the bus clock rests high after it
	always_ff @(posedge sda_i or posedge rst_i or posedge start_flag) begin
		if (rst_i || start_flag) begin
			stop_flag <= 1'b0;
		end else if (scl_i) begin
			stop_flag <= 1'b1;
		end
	end
	// start marker must survive the falling clock after it and be seen at the first
	// rising clock; it is consumed there, as that edge also carries the first address bit
	// a falling-edge clear would lose the start before the protocol logic ever saw it
	always_ff @(posedge scl_i or posedge rst_i) begin
		if (rst_i) begin
			start_ack <= 1'b0;
		end else begin
			start_ack <= start_flag;
		end
	end

	// busy level crosses into the bus clock through two flops
	always_ff @(posedge scl_i or posedge rst_i) begin
		if (rst_i) begin
			busy_link1 <= 1'b0;
			busy_link <= 1'b0;
		end else begin
			busy_link1 <= sys.busy;
			busy_link <= busy_link1;
		end
	end

	// protocol: sample on rising clock; flags from markers act here too
	always_comb begin
		next_link = link;
		page_we = 1'b0;
		page_wa = link.ptr[4:0];
		if (busy_link) begin
			next_link.phase = st_idle;
			next_link.ack_now = 1'b0;
		end else if (start_flag) begin
			// stop needs no branch here: no rising clock follows it before the next start,
			// so the write launch and the read abort are handled outside this process
			// first rising clock after start already carries the first address bit
			next_link.phase = st_dev;
			next_link.shift = {link.shift[6:0], sda_i};
			next_link.bit_cnt = 3'h1;
			next_link.ack_now = 1'b0;
			next_link.count = eeprom_pkg::count_reset;
		end else if (link.ack_now) begin
			next_link.ack_now = 1'b0; // ninth clock taken
		end else if (link.phase == st_rack) begin
			// master acknowledge continues
			next_link.phase = sda_i ? st_idle : st_rdata;
			next_link.tx = mem[link.ptr];
		end else if (link.phase != st_idle && link.phase != st_rdata) begin
			next_link.shift = {link.shift[6:0], sda_i};
			next_link.bit_cnt = 3'(link.bit_cnt + 3'h1);
			if (link.bit_cnt == eeprom_pkg::last_bit) begin
				next_link.ack_now = 1'b1;
				case (link.phase)
					st_dev: begin
						if (link.shift[6:3] == eeprom_pkg::type_prefix &&
							link.shift[2:0] == {strap_pin_bit2, strap_pin_bit1, strap_pin_bit0}) begin
							next_link.phase = sda_i ? st_rdata : st_hi;
							next_link.tx = mem[link.ptr];
						end else begin
							next_link.ack_now = 1'b0;
							next_link.phase = st_idle;
						end
					end
					st_hi: begin
						next_link.hi = {link.shift[6:0], sda_i};
						next_link.phase = st_lo;
					end
					st_lo: begin
						// only thirteen bits kept
						next_link.ptr = {link.hi[4:0], link.shift[6:0], sda_i};
						next_link.wbase = {link.hi[4:0], link.shift[6:0], sda_i};
						next_link.phase = st_wdata;
					end
					st_wdata: begin
						page_we = 1'b1;
						next_link.ptr = page_step(link.ptr);
						if (link.count != 6'(eeprom_pkg::page_bytes)) begin
							next_link.count = 6'(link.count + 6'h01);
						end
					end
					default: next_link.phase = st_idle;
				endcase
			end
		end
	end

	// read output shift on falling clock, separate so data moves with clock low
	logic [2:0] rd_bit;
	logic sda_drive;
	logic [12:0] rd_ptr_inc;
	// a stop releases the line at once and abandons the byte
	always_ff @(negedge scl_i or posedge rst_i or posedge stop_flag) begin
		if (rst_i || stop_flag) begin
			rd_bit <= 3'h0;
			sda_drive <= 1'b0;
		end else if (link.ack_now) begin
			sda_drive <= 1'b1;
			rd_bit <= 3'h0;
		end else if (link.phase == st_rdata) begin
			sda_drive <= ~link.tx[3'h7 - rd_bit];
			rd_bit <= 3'(rd_bit + 3'h1);
		end else begin
			sda_drive <= 1'b0;
			rd_bit <= 3'h0;
		end
	end
	assign sda_o = 1'b0;
	assign sda_oe_o = sda_drive;
	// wrap across the whole array
	assign rd_ptr_inc = 13'(link.ptr + 13'h0001);

	always_ff @(posedge scl_i or posedge rst_i) begin
		if (rst_i) begin
			link <= '{phase: st_idle, bit_cnt: 3'h0, shift: 8'h00, ack_now: 1'b0, hi: 8'h00,
				ptr: eeprom_pkg::ptr_reset, wbase: eeprom_pkg::ptr_reset,
				count: eeprom_pkg::count_reset, tx: 8'h00};
		end else begin
			link <= next_link;
			// eighth read bit on the line (counter wrapped to zero): the falling edge after
			// this one ends the byte, so the pointer moves now
			// the ninth-clock acknowledge also has a zero count, hence the ack_now guard
			if (link.phase == st_rdata && rd_bit == 3'h0 && !link.ack_now && !stop_flag && !start_flag) begin
				link.phase <= st_rack;
				link.ptr <= rd_ptr_inc;
			end
		end
	end
	always_ff @(posedge scl_i) begin
		if (page_we) begin
			page[page_wa] <= {link.shift[6:0], sda_i};
		end
	end

	// system side: write timer and array programming
	always_comb begin
		next_sys = sys;
		next_sys.busy_sync = {sys.busy_sync[0], 1'b0};
		next_sys.stop_sync = {sys.stop_sync[0], stop_flag};
		next_sys.go_seen = sys.stop_sync[1];
		// count and base are quiet here: the bus clock rests high after a stop,
		// so the synchronised stop level is the handshake for them
		// a stop seen while busy is ignored like everything else
		if (sys.stop_sync[1] && !sys.go_seen && !sys.busy && link.count != eeprom_pkg::count_reset) begin
			next_sys.busy = 1'b1;
			next_sys.timer = 32'(write_cycles);
			next_sys.idx = eeprom_pkg::count_reset;
			next_sys.base = link.wbase;
			next_sys.count = link.count;
			next_sys.guard = guard_sync[1];
		end else if (sys.busy) begin
			if (sys.idx != sys.count) begin
				next_sys.idx = 6'(sys.idx + 6'h01);
			end
			next_sys.timer = 32'(sys.timer - 32'h1);
			if (sys.timer == 32'h1) begin
				next_sys.busy = 1'b0;
			end
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			guard_sync <= 2'h0;
			sys <= '0;
		end else begin
			guard_sync <= {guard_sync[0], write_guard_i};
			sys <= next_sys;
		end
	end
	// program one buffered byte per clock, inside the page
	always_ff @(posedge clk_i) begin
		if (sys.busy && !sys.guard && sys.idx != sys.count) begin
			mem[{sys.base[12:5], 5'(sys.base[4:0] + sys.idx[4:0])}] <= page[5'(sys.base[4:0] + sys.idx[4:0])];
		end
	end
	assign busy_o = sys.busy;

	// checks
	chk_busy_no_ack: assert property (@(posedge scl_i) disable iff (rst_i)
		busy_link |=> !link.ack_now) else $error("acknowledge during write cycle");
	chk_count_cap: assert property (@(posedge scl_i) disable iff (rst_i)
		link.count <= 6'h20) else $error("page count past one page");
	chk_page_wrap: assert property (@(posedge scl_i) disable iff (rst_i)
		page_we |=> link.ptr[12:5] == $past(link.ptr[12:5])) else $error("upper bits moved");
	chk_stop_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		stop_flag |-> !sda_oe_o) else $error("line held after stop");
	chk_bad_dev: assert property (@(posedge scl_i) disable iff (rst_i)
		link.phase == st_dev && link.bit_cnt == 3'h7 && link.shift[6:3] != eeprom_pkg::type_prefix
		&& !busy_link && !stop_flag && !start_flag |=> !link.ack_now) else $error("foreign address ack");
	chk_busy_len: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(sys.busy) |-> sys.busy [*8]) else $error("write cycle too short");
	chk_guard_block: assert property (@(posedge clk_i) disable iff (rst_i)
		sys.busy && sys.guard |=> $stable(sys.guard) || !sys.busy) else $error("guard changed");
	chk_start_dev: assert property (@(posedge scl_i) disable iff (rst_i)
		start_flag && !busy_link && !stop_flag |=> link.phase == st_dev) else $error("start missed");
endmodule

// file: pkg/eeprom_pkg.sv
// constants shared by the serial eeprom slave
package eeprom_pkg;
	localparam logic [3:0] type_prefix = 4'ha; // memory-type prefix code on the bus
	localparam int mem_bytes = 8192;
	localparam int addr_bits = 13;
	localparam int page_bits = 5;
	localparam int page_bytes = 32;
	localparam logic [2:0] last_bit = 3'h7;
	localparam logic [12:0] ptr_reset = 13'h0000;
	localparam logic [5:0] count_reset = 6'h00;
	localparam int clk_mhz = 50;
	localparam int write_time_us = 10000; // longest internal write time
	localparam int write_cycles = write_time_us * clk_mhz;
endpackage
